//--- logic/asrx_baud.sv
`timescale 1ns/1ps
`default_nettype none
module asrx_baud (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic high_speed,
  input wire logic [7:0] divisor,
  output logic tick
);
  import asrx_pkg::*;

  // divider count, prescale step and registered tick
  typedef struct packed {
    logic [7:0] cnt;
    logic [1:0] pre;
    logic tick;
  } asrx_baud_type;

  asrx_baud_type st_r;
  asrx_baud_type st_nxt;

  // held in reset while idle so the first tick lines up with the start edge
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run) begin
      st_nxt.cnt = divisor;
      st_nxt.pre = 2'h0;
    end else if (st_r.cnt == 8'h00) begin
      st_nxt.cnt = divisor;
      // high speed gives x16 directly, low speed divides by four more
      if (high_speed || st_r.pre == LOW_PRESC_LAST) begin
        st_nxt.pre = 2'h0;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.pre = st_r.pre + 2'h1;
      end
    end else begin
      st_nxt.cnt = st_r.cnt - 8'h01;
    end
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule : asrx_baud
`default_nettype wire

//--- logic/asrx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module asrx_fifo (
  input wire logic mclk,
  input wire logic rst,
  input wire logic push,
  input wire logic [asrx_pkg::WORD_W-1:0] wdata,
  input wire logic pop,
  output logic full,
  output logic empty,
  output logic [asrx_pkg::WORD_W-1:0] head
);
  import asrx_pkg::*;

  // entry 0 is always the oldest word, so the head comes from a register
  typedef struct packed {
    logic [WORD_W-1:0] e0;
    logic [WORD_W-1:0] e1;
    logic [1:0] cnt;
  } asrx_fifo_type;

  asrx_fifo_type st_r;
  asrx_fifo_type st_nxt;
  logic do_pop;
  logic do_push;
  logic [1:0] pos;

  // pop shifts entry 1 down; a push on a full queue is refused unless a pop comes in the same cycle
  always_comb begin
    st_nxt = st_r;
    do_pop = pop && (st_r.cnt != 2'h0);
    do_push = push && ((st_r.cnt != FIFO_DEPTH) || do_pop);
    pos = do_pop ? st_r.cnt - 2'h1 : st_r.cnt;
    if (do_pop) begin
      st_nxt.e0 = st_r.e1;
    end
    if (do_push) begin
      if (pos == 2'h0) begin
        st_nxt.e0 = wdata;
      end else begin
        st_nxt.e1 = wdata;
      end
    end
    st_nxt.cnt = do_push ? pos + 2'h1 : pos;
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign full = (st_r.cnt == FIFO_DEPTH);
  assign empty = (st_r.cnt == 2'h0);
  assign head = st_r.e0;

  // words leave in the order they came
  a_fifo_order:
    assert property (@(posedge mclk) disable iff (rst)
      (st_r.cnt == FIFO_DEPTH) && pop && !push |=> head == $past(st_r.e1))
    else $error("fifo head not the second word after pop");
endmodule : asrx_fifo
`default_nettype wire

//--- logic/asrx_rx.sv
// Summary of operation
// - bits recovered by x16 oversampling shifter
// - reception starts only with continuous receive enable
// - stop sampled, word moved, receive flag set
// - interrupt only while receive interrupt enable set
// - flag read-only, clears when buffer empties
// - two-deep queue plus word in shifter
// - full at third stop: overrun, word lost
// - overrun cleared only by dropping receive enable
// - overrun blocks every move into buffer
// - low stop bit sets framing error
// - ninth bit and framing error queued
// - async when sync clear, port enabled
// - nine data bits when nine-bit enable set
// - bit period from divisor and speed select
// - address detect passes only address frames, in nine-bit mode
// - address detect at bit 3; reset zeros
// - start, 8 or 9 bits lsb first, stop
// - baud clock x16 or x64 of bit rate
// - reception halted during sleep
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module asrx_rx (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [asrx_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_input_pin,
  input wire logic sleep_mode,
  output logic rx_irq
);
  import asrx_pkg::*;

  // all state of the receiver and its registers
  typedef struct packed {
    logic [1:0] rx_meta;      // pin synchroniser, bit 1 is the safe copy
    logic rx_prev;            // previous synchronised level for edge find
    asrx_state_type fsm;      // frame state
    logic [3:0] cnt;          // oversample tick count within a bit
    logic [3:0] bit_idx;      // data bit being received
    logic [8:0] shift;        // receive_shift_register
    logic overrun;            // overrun_error
    logic [4:0] ctrl;         // writable receive_status_control bits 7..3
    logic [7:0] txbuf;        // transmit_buffer, storage only
    logic [7:0] enables;      // peripheral_irq_enables
    logic [7:0] txctrl;       // transmit_status_control
    logic [7:0] baud;         // baud_divisor
    logic [7:0] rdata;        // read data captured in setup phase
    logic err;                // unmapped access captured in setup phase
    logic rd_ok;              // buffer read captured a queued word
  } asrx_core_type;

  asrx_core_type st_r;
  asrx_core_type st_nxt;

  // address match against a register index
  function automatic logic asrx_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a == {2'h0, idx, 2'h0};
  endfunction : asrx_hit

  // control fields pulled out of the registers
  logic port_en;
  logic nine_en;
  logic cont_en;
  logic addr_det;
  logic rx_on;          // receiver allowed to run
  logic rx_s;           // synchronised serial level
  logic tick;           // x16 oversample tick
  logic frame_done;     // stop bit sampled this cycle
  logic ninth;          // ninth bit of the finished frame
  logic drop_addr;      // frame filtered by address detect
  logic push;           // move shifter into buffer
  logic set_overrun;    // overrun detected
  logic pop;            // software read of the buffer
  logic fifo_full;
  logic fifo_empty;
  logic [WORD_W-1:0] head;
  logic [WORD_W-1:0] word;
  logic receive_flag;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] rxctrl_rd;

  assign port_en = st_r.ctrl[RC_PORT_EN-3];
  assign nine_en = st_r.ctrl[RC_NINE_EN-3];
  assign cont_en = st_r.ctrl[RC_CONT_EN-3];
  assign addr_det = st_r.ctrl[RC_ADDR_DET-3];
  assign rx_s = st_r.rx_meta[1];

  // async mode needs sync clear, port on, receive on and no sleep
  assign rx_on = port_en && !st_r.txctrl[TX_SYNC] && cont_en && !sleep_mode;

  // baud generator runs only inside a frame, restarting on each start edge
  asrx_baud u_baud (
    .mclk(mclk),
    .rst(rst),
    .run(rx_on && (st_r.fsm != ST_IDLE)),
    .high_speed(st_r.txctrl[TX_HIGH_SPEED]),
    .divisor(st_r.baud),
    .tick(tick)
  );

  // end of frame: stop bit sampled at its middle
  assign frame_done = (st_r.fsm == ST_STOP) && tick && (st_r.cnt == OVS_LAST);
  assign ninth = nine_en && st_r.shift[8];
  // a filtered data frame never reaches the buffer or the flag
  assign drop_addr = addr_det && nine_en && !ninth;
  // overrun blocks moves; a full buffer turns the frame into an overrun
  assign push = frame_done && !st_r.overrun && !drop_addr && !fifo_full;
  assign set_overrun = frame_done && !st_r.overrun && !drop_addr && fifo_full;
  // framing status from the stop sample, queued with the ninth bit
  assign word = {!rx_s, ninth, st_r.shift[7:0]};

  // apb phases
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  // popping only a word that the setup phase really saw avoids losing one
  assign pop = rd_acc && asrx_hit(paddr, IDX_RXBUF) && st_r.rd_ok;

  // two-deep queue of received words
  asrx_fifo u_fifo (
    .mclk(mclk),
    .rst(rst),
    .push(push),
    .wdata(word),
    .pop(pop),
    .full(fifo_full),
    .empty(fifo_empty),
    .head(head)
  );

  // flag follows the queue: hardware sets it, reading it empty clears it
  assign receive_flag = !fifo_empty;
  assign rx_irq = receive_flag && st_r.enables[ENA_RX];

  // status view: head entry supplies framing error and ninth bit
  assign rxctrl_rd = {st_r.ctrl, head[WORD_W-1], st_r.overrun, head[WORD_W-2]};

  // next-state logic for frame reception and registers
  always_comb begin
    st_nxt = st_r;
    // pin passes two flops before anything reads it
    st_nxt.rx_meta = {st_r.rx_meta[0], serial_input_pin};
    st_nxt.rx_prev = rx_s;
    case (st_r.fsm)
      ST_IDLE: begin
        // idle-high line, falling edge begins a frame
        if (rx_on && st_r.rx_prev && !rx_s) begin
          st_nxt.fsm = ST_START;
          st_nxt.cnt = 4'h0;
        end
      end
      ST_START: begin
        if (tick) begin
          if (st_r.cnt == OVS_MID) begin
            // a glitch that is high again at mid-bit is no start
            if (rx_s) begin
              st_nxt.fsm = ST_IDLE;
            end else begin
              st_nxt.fsm = ST_DATA;
              st_nxt.bit_idx = 4'h0;
              st_nxt.shift = 9'h000;
            end
            st_nxt.cnt = 4'h0;
          end else begin
            st_nxt.cnt = st_r.cnt + 4'h1;
          end
        end
      end
      ST_DATA: begin
        if (tick) begin
          if (st_r.cnt == OVS_LAST) begin
            // sixteen ticks after the previous middle: lsb first
            st_nxt.shift[st_r.bit_idx] = rx_s;
            st_nxt.cnt = 4'h0;
            if (st_r.bit_idx == (nine_en ? LAST_BIT9 : LAST_BIT8)) begin
              st_nxt.fsm = ST_STOP;
            end else begin
              st_nxt.bit_idx = st_r.bit_idx + 4'h1;
            end
          end else begin
            st_nxt.cnt = st_r.cnt + 4'h1;
          end
        end
      end
      ST_STOP: begin
        if (tick) begin
          if (st_r.cnt == OVS_LAST) begin
            st_nxt.fsm = ST_IDLE;
            st_nxt.cnt = 4'h0;
          end else begin
            st_nxt.cnt = st_r.cnt + 4'h1;
          end
        end
      end
      default: begin
        st_nxt.fsm = ST_IDLE;
      end
    endcase
    // dropping enable, sync select or entering sleep abandons the frame
    if (!rx_on) begin
      st_nxt.fsm = ST_IDLE;
      st_nxt.cnt = 4'h0;
    end
    // overrun is sticky until receive enable is cleared
    if (!cont_en) begin
      st_nxt.overrun = 1'b0;
    end else if (set_overrun) begin
      st_nxt.overrun = 1'b1;
    end
    // register writes take effect at the access edge, low byte lane
    if (wr_acc && pstrb[0]) begin
      if (asrx_hit(paddr, IDX_RXCTRL)) begin
        st_nxt.ctrl = pwdata[7:3];
      end
      if (asrx_hit(paddr, IDX_TXBUF)) begin
        st_nxt.txbuf = pwdata[7:0];
      end
      if (asrx_hit(paddr, IDX_ENABLES)) begin
        st_nxt.enables = pwdata[7:0];
      end
      if (asrx_hit(paddr, IDX_TXCTRL)) begin
        // transmitter empty bit is read-only and stays set
        st_nxt.txctrl = (pwdata[7:0] & TXCTRL_WMASK) | RST_TXCTRL;
      end
      if (asrx_hit(paddr, IDX_BAUD)) begin
        st_nxt.baud = pwdata[7:0];
      end
    end
    // read data is captured in setup so it stands through the access phase
    if (setup) begin
      st_nxt.err = 1'b0;
      st_nxt.rd_ok = 1'b0;
      st_nxt.rdata = 8'h00;
      if (asrx_hit(paddr, IDX_FLAGS)) begin
        st_nxt.rdata[FLAG_RX] = receive_flag;
      end else if (asrx_hit(paddr, IDX_RXCTRL)) begin
        st_nxt.rdata = rxctrl_rd;
      end else if (asrx_hit(paddr, IDX_TXBUF)) begin
        st_nxt.rdata = st_r.txbuf;
      end else if (asrx_hit(paddr, IDX_RXBUF)) begin
        st_nxt.rdata = head[7:0];
        st_nxt.rd_ok = !pwrite && !fifo_empty;
      end else if (asrx_hit(paddr, IDX_ENABLES)) begin
        st_nxt.rdata = st_r.enables;
      end else if (asrx_hit(paddr, IDX_TXCTRL)) begin
        st_nxt.rdata = st_r.txctrl;
      end else if (asrx_hit(paddr, IDX_BAUD)) begin
        st_nxt.rdata = st_r.baud;
      end else begin
        // unmapped: error answer, data zero
        st_nxt.err = 1'b1;
      end
    end
  end

  // state register; pin synchroniser resets to the idle-high level
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.rx_meta <= 2'h3;
      st_r.rx_prev <= 1'b1;
      st_r.fsm <= ST_IDLE;
      st_r.ctrl <= RST_RXCTRL[7:3];
      st_r.txbuf <= RST_TXBUF;
      st_r.enables <= RST_ENABLES;
      st_r.txctrl <= RST_TXCTRL;
      st_r.baud <= RST_BAUD;
    end else begin
      st_r <= st_nxt;
    end
  end

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && st_r.err;
  assign prdata = {24'h000000, st_r.rdata};

  a_push_sets_flag:
    assert property (@(posedge mclk) disable iff (rst)
      push |=> receive_flag)
    else $error("accepted frame did not raise the receive flag");

  a_irq_gated:
    assert property (@(posedge mclk) disable iff (rst)
      rx_irq |-> st_r.enables[ENA_RX] && !fifo_empty)
    else $error("interrupt without enable or pending word");

  a_overrun_set:
    assert property (@(posedge mclk) disable iff (rst)
      frame_done && fifo_full && cont_en && !drop_addr && !pop |=> st_r.overrun && fifo_full)
    else $error("third frame on full buffer did not overrun");

  // the clear follows the enable bit by one register stage
  a_overrun_clear:
    assert property (@(posedge mclk) disable iff (rst)
      !cont_en |=> !st_r.overrun)
    else $error("overrun not cleared by dropping receive enable");

  a_overrun_block:
    assert property (@(posedge mclk) disable iff (rst)
      st_r.overrun && fifo_empty && !pop |=> fifo_empty)
    else $error("word moved into buffer during overrun");

  a_framing_queued:
    assert property (@(posedge mclk) disable iff (rst)
      push && fifo_empty |=> head[WORD_W-1] == !$past(rx_s))
    else $error("framing status does not match stop sample");

  a_addr_filter:
    assert property (@(posedge mclk) disable iff (rst)
      frame_done && addr_det && nine_en && !st_r.shift[8] && fifo_empty && !st_r.overrun
      |=> fifo_empty && !st_r.overrun)
    else $error("data frame passed address detect");

  a_start_edge:
    assert property (@(posedge mclk) disable iff (rst)
      st_r.fsm == ST_IDLE && rx_on && st_r.rx_prev && !rx_s |=> st_r.fsm == ST_START)
    else $error("falling edge did not begin a frame");

  a_halt_off:
    assert property (@(posedge mclk) disable iff (rst)
      !rx_on |=> st_r.fsm == ST_IDLE)
    else $error("receiver ran while disabled or asleep");
endmodule : asrx_rx
`default_nettype wire

//--- pkg/asrx_pkg.sv
`default_nettype none
package asrx_pkg;
  // apb address width; each register index times four is its byte address
  localparam int ADDR_W = 12;
  // register indices; the byte address is the index times four
  localparam logic [7:0] IDX_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_RXCTRL = 8'h18;
  localparam logic [7:0] IDX_TXBUF = 8'h19;
  localparam logic [7:0] IDX_RXBUF = 8'h1A;
  localparam logic [7:0] IDX_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_TXCTRL = 8'h98;
  localparam logic [7:0] IDX_BAUD = 8'h99;
  // receive_status_control fields
  localparam int RC_PORT_EN = 7;
  localparam int RC_NINE_EN = 6;
  localparam int RC_SINGLE = 5;
  localparam int RC_CONT_EN = 4;
  localparam int RC_ADDR_DET = 3;
  localparam int RC_FRAME_ERR = 2;
  localparam int RC_OVERRUN = 1;
  localparam int RC_NINTH = 0;
  // flag and enable position of the receiver
  localparam int FLAG_RX = 5;
  localparam int ENA_RX = 5;
  // transmit_status_control fields used here
  localparam int TX_SYNC = 4;
  localparam int TX_HIGH_SPEED = 2;
  localparam logic [7:0] TXCTRL_WMASK = 8'hF5;
  // reset values
  localparam logic [7:0] RST_RXCTRL = 8'h00;
  localparam logic [7:0] RST_TXBUF = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_TXCTRL = 8'h02;
  localparam logic [7:0] RST_BAUD = 8'h00;
  // oversampling: 16 ticks per bit, middle of bit at tick 8
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  // low speed: four x16 prescale steps make the x64 rate
  localparam logic [1:0] LOW_PRESC_LAST = 2'h3;
  // index of the last data bit for 8 and 9 bit frames
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;
  // queued word: {framing error, ninth bit, data}
  localparam int WORD_W = 10;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  // receiver states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_START = 4'h2,
    ST_DATA = 4'h4,
    ST_STOP = 4'h8
  } asrx_state_type;
endpackage : asrx_pkg
`default_nettype wire

//--- verification/asrx_line_tx.sv
`timescale 1ns/1ps
`default_nettype none
// far-end transmitter: drives the idle-high serial line, one frame per call
module asrx_line_tx (
  input wire logic mclk,
  output logic line
);
  // line rests high between frames
  initial line = 1'b1;
  // start bit, 8 or 9 data bits lsb first, stop bit; cyc is mclk per bit
  task automatic send(input logic [8:0] d, input logic nine, input logic stop_ok, input int cyc);
    int i;
    @(posedge mclk);
    line <= 1'b0;
    repeat (cyc) @(posedge mclk);
    // data bits, least significant first
    for (i = 0; i < (nine ? 9 : 8); i++) begin
      line <= d[i];
      repeat (cyc) @(posedge mclk);
    end
    // a low stop bit is the one fault that scenarios command
    line <= stop_ok;
    repeat (cyc) @(posedge mclk);
    line <= 1'b1;
    // after a broken stop a high gap is needed so the next start edge exists
    if (!stop_ok) repeat (cyc) @(posedge mclk);
  endtask : send
endmodule : asrx_line_tx
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import asrx_pkg::*;
  // one expected read: byte address, data, error answer
  typedef struct {logic [ADDR_W-1:0] a; logic [31:0] d; logic e;} asrx_note_type;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hF;
  logic sleep_mode = 1'b0;
  logic line;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_irq;
  int n_fail = 0;
  int num_checks = 0;
  asrx_note_type notes[$]; // reads still to be answered, oldest first
  logic [7:0] b [0:3]; // random payloads
  // 10 MHz clock
  always #50 mclk = ~mclk;
  asrx_rx dut_u (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_input_pin(line), .sleep_mode(sleep_mode), .rx_irq(rx_irq));
  asrx_line_tx tx_u (.mclk(mclk), .line(line));
  // printed offsets are indices, so the byte address is four times
  function automatic logic [ADDR_W-1:0] ba(input logic [7:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction : ba
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected 0x%h seen 0x%h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // one apb transfer; held until pready is seen high, then one idle edge
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    // bounded wait for the slave answer
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      $display("Error pready expected 1 seen %b", pready);
      n_fail++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(ba(idx), 1'b1, d);
  endtask : wr
  // note the expected answer, then read
  task automatic rd(input logic [7:0] idx, input logic [31:0] x);
    notes.push_back('{ba(idx), x, 1'b0});
    xfer(ba(idx), 1'b0, 8'h00);
  endtask : rd
  task automatic sect(input string nm);
    $display("test %s done", nm);
  endtask : sect
  // watcher: each completed read is matched to the oldest note
  always @(posedge mclk) begin
    asrx_note_type n;
    if (psel && penable && pready && !pwrite) begin
      if (notes.size() == 0) begin
        n_fail++;
        $display("Error read expected none seen 0x%h", prdata);
      end else begin
        n = notes.pop_front();
        check($sformatf("reg_%h", n.a), prdata, n.d);
        check("pslverr", {31'h0, pslverr}, {31'h0, n.e});
      end
    end
  end
  // a hang is cut short here
  initial begin
    repeat (100000) @(posedge mclk);
    $display("Error run expected end seen timeout");
    n_fail++;
    finish_test();
  end
  // main sequence
  initial begin
    int i;
    int cyc;
    logic [7:0] bd;
    logic hs;
    void'($urandom(7));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    // reset values and an unmapped hole
    rd(IDX_FLAGS, 32'h00);
    rd(IDX_RXCTRL, 32'h00);
    rd(IDX_TXBUF, 32'h00);
    rd(IDX_RXBUF, 32'h00);
    rd(IDX_ENABLES, 32'h00);
    rd(IDX_TXCTRL, 32'h02);
    rd(IDX_BAUD, 32'h00);
    notes.push_back('{12'h004, 32'h0, 1'b1});
    xfer(12'h004, 1'b0, 8'h00);
    sect("reset");
    // each blocking condition in turn: no frame gets through
    wr(IDX_TXCTRL, 8'h04);
    wr(IDX_ENABLES, 8'h20);
    for (i = 0; i < 4; i++) begin
      case (i)
        0: wr(IDX_RXCTRL, 8'h80);
        1: wr(IDX_RXCTRL, 8'h10);
        2: begin
          wr(IDX_RXCTRL, 8'h90);
          wr(IDX_TXCTRL, 8'h14);
        end
        default: begin
          wr(IDX_TXCTRL, 8'h04);
          sleep_mode <= 1'b1;
        end
      endcase
      tx_u.send(9'($urandom % 256), 1'b0, 1'b1, 16);
      rd(IDX_FLAGS, 32'h00);
    end
    sleep_mode <= 1'b0;
    sect("blocked");
    // plain frame, flag, interrupt and masking
    b[0] = 8'($urandom);
    tx_u.send({1'b0, b[0]}, 1'b0, 1'b1, 16);
    rd(IDX_FLAGS, 32'h20);
    check("rx_irq", {31'h0, rx_irq}, 32'h1);
    wr(IDX_ENABLES, 8'h00);
    check("rx_irq", {31'h0, rx_irq}, 32'h0);
    wr(IDX_FLAGS, 8'h00);
    rd(IDX_FLAGS, 32'h20);
    rd(IDX_RXCTRL, 32'h90);
    rd(IDX_RXBUF, {24'h0, b[0]});
    rd(IDX_FLAGS, 32'h00);
    sect("receive");
    // three frames into a two-deep queue
    wr(IDX_ENABLES, 8'h20);
    for (i = 0; i < 3; i++) begin
      b[i] = 8'($urandom);
      tx_u.send({1'b0, b[i]}, 1'b0, 1'b1, 16);
    end
    rd(IDX_RXCTRL, 32'h92);
    rd(IDX_RXBUF, {24'h0, b[0]});
    rd(IDX_RXBUF, {24'h0, b[1]});
    rd(IDX_FLAGS, 32'h00);
    tx_u.send(9'h0A5, 1'b0, 1'b1, 16);
    rd(IDX_FLAGS, 32'h00);
    wr(IDX_RXCTRL, 8'h80);
    rd(IDX_RXCTRL, 32'h80);
    wr(IDX_RXCTRL, 8'h90);
    sect("overrun");
    // broken stop queued beside its word
    b[0] = 8'($urandom);
    b[1] = 8'($urandom);
    tx_u.send({1'b0, b[0]}, 1'b0, 1'b0, 16);
    tx_u.send({1'b0, b[1]}, 1'b0, 1'b1, 16);
    rd(IDX_RXCTRL, 32'h94);
    rd(IDX_RXBUF, {24'h0, b[0]});
    rd(IDX_RXCTRL, 32'h90);
    rd(IDX_RXBUF, {24'h0, b[1]});
    sect("framing");
    // nine-bit frames and address filtering
    b[2] = 8'($urandom);
    b[3] = 8'($urandom);
    wr(IDX_RXCTRL, 8'hD0);
    tx_u.send({1'b1, b[2]}, 1'b1, 1'b1, 16);
    rd(IDX_RXCTRL, 32'hD1);
    rd(IDX_RXBUF, {24'h0, b[2]});
    wr(IDX_RXCTRL, 8'hD8);
    tx_u.send({1'b0, b[3]}, 1'b1, 1'b1, 16);
    rd(IDX_FLAGS, 32'h00);
    tx_u.send({1'b1, b[3]}, 1'b1, 1'b1, 16);
    rd(IDX_FLAGS, 32'h20);
    rd(IDX_RXCTRL, 32'hD9);
    rd(IDX_RXBUF, {24'h0, b[3]});
    wr(IDX_RXCTRL, 8'hD0);
    tx_u.send({1'b0, b[2]}, 1'b1, 1'b1, 16);
    rd(IDX_RXCTRL, 32'hD0);
    rd(IDX_RXBUF, {24'h0, b[2]});
    sect("ninth");
    // bit period from divisor and speed select: 16 ticks, tick x1 or x4
    wr(IDX_RXCTRL, 8'h90);
    for (i = 0; i < 3; i++) begin
      hs = (i != 2);
      bd = 8'(i);
      cyc = 16 * (int'(bd) + 1) * (hs ? 1 : 4);
      wr(IDX_TXCTRL, hs ? 8'h04 : 8'h00);
      wr(IDX_BAUD, bd);
      // speed select reads back beside the read-only transmitter empty bit
      rd(IDX_TXCTRL, hs ? 32'h06 : 32'h02);
      rd(IDX_BAUD, {24'h0, bd});
      b[0] = 8'($urandom);
      tx_u.send({1'b0, b[0]}, 1'b0, 1'b1, cyc);
      rd(IDX_RXBUF, {24'h0, b[0]});
    end
    sect("baud");
    repeat (2) @(posedge mclk);
    finish_test();
  end
endmodule : tb
`default_nettype wire
